// [rtl/rte_dev.sv]
// Purpose: RTC EEPROM two-wire slave: reads, polling, write cycle, trims.
// Assumes: SCL and SDA are asynchronous; both pass two flip-flops.
// Notes: Memory is written as bytes arrive; the stop starts the busy time.
`timescale 1ns/100ps
module rte_dev #(
   parameter int WR_CYCLES = rte_pkg::WR_CYCLES,
   parameter int ADJ_PERIOD = rte_pkg::ADJ_PERIOD
) (
   input wire logic clock, // System clock
   input wire logic resetn, // Async reset, active low
   rte_if.dev bus, // Two-wire link
   output logic busy, // Nonvolatile write cycle running
   output logic [5:0] load_cap_trim, // Analog load capacitance code
   output logic [2:0] freq_trim, // Digital frequency trim code
   input wire logic osc_pulse, // Oscillator pulse, one cycle
   output logic osc_pulse_adj // Trimmed oscillator pulse
);
   if (WR_CYCLES < 1 || WR_CYCLES >= 2 ** 24) begin : g_chk_wr
      $error("WR_CYCLES out of range");
   end
   if (ADJ_PERIOD < 8 || ADJ_PERIOD >= 2 ** 24) begin : g_chk_adj
      $error("ADJ_PERIOD out of range");
   end

   function automatic logic [15:0] next_addr(input logic [15:0] a,
      input logic [15:0] mask, input logic keep);
      logic [15:0] inc;
      inc = a + 16'h0001;
      next_addr = keep ? ((a & ~mask) | (inc & mask)) : (inc & mask);
   endfunction : next_addr

   logic [1:0] scl_s;
   logic [1:0] sda_s;
   logic scl_d;
   logic sda_d;
   rte_pkg::rte_dst_t st_r;
   logic [7:0] sh_r;
   logic [3:0] bit_r;
   logic [1:0] idx_r;
   logic rd_r;
   logic ctl_r;
   logic [7:0] hi_r;
   logic wrote_r;
   logic ack_r;
   logic [15:0] addr_r;
   logic sda_oe_n_r;
   logic [23:0] wcnt_r;
   logic busy_r;
   logic [5:0] cap_r;
   logic [2:0] ftrim_r;
   logic [23:0] acnt_r;
   logic [1:0] owe_r;
   logic adj_r;
   logic [7:0] arr_mem [0:rte_pkg::ARR_BYTES-1];
   logic [7:0] ctl_mem [0:rte_pkg::CTL_BYTES-1];

   // Link synchronisers and edge detection
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         scl_s <= 2'h3;
         sda_s <= 2'h3;
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_s <= {scl_s[0], bus.scl};
         sda_s <= {sda_s[0], bus.sda};
         scl_d <= scl_s[1];
         sda_d <= sda_s[1];
      end
   end

   wire sda_in = sda_s[1];
   wire scl_rise = scl_s[1] & ~scl_d;
   wire scl_fall = ~scl_s[1] & scl_d;
   wire start = scl_s[1] & scl_d & sda_d & ~sda_in;
   wire stop = scl_s[1] & scl_d & ~sda_d & sda_in;
   wire arr_hit = sh_r[7:1] == rte_pkg::ARR_ID;
   wire ctl_hit = sh_r[7:1] == rte_pkg::CTL_ID;
   wire addr_hit = arr_hit | ctl_hit;
   wire byte_end = (st_r == rte_pkg::S_RX) && scl_fall && (bit_r == rte_pkg::BITS);
   wire wr_en = byte_end && (idx_r == rte_pkg::IDX_DATA) && !rd_r;
   wire [rte_pkg::CTL_AW-1:0] ctl_a = addr_r[rte_pkg::CTL_AW-1:0];
   wire [rte_pkg::ARR_AW-1:0] arr_a = addr_r[rte_pkg::ARR_AW-1:0];
   wire [7:0] rd_byte = ctl_r ? ctl_mem[ctl_a] : arr_mem[arr_a];
   wire [15:0] rd_mask = ctl_r ? rte_pkg::CTL_MASK : rte_pkg::ARR_MASK;
   wire [15:0] wr_mask = ctl_r ? rte_pkg::CTL_PAGE_MASK : rte_pkg::ARR_PAGE_MASK;
   wire load_tx = scl_fall && (((st_r == rte_pkg::S_ACK) && rd_r)
      || ((st_r == rte_pkg::S_MACK) && ack_r));
   wire wr_done = wcnt_r == 24'(WR_CYCLES - 1);
   // The SCL rise that opens a stop has already counted as bit one
   wire go_busy = wrote_r && (st_r == rte_pkg::S_RX) && (bit_r == 4'h1);

   // Protocol engine
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         st_r <= rte_pkg::S_IDLE;
         sh_r <= 8'h00;
         bit_r <= 4'h0;
         idx_r <= rte_pkg::IDX_SLAVE;
         rd_r <= 1'b0;
         ctl_r <= 1'b0;
         hi_r <= 8'h00;
         wrote_r <= 1'b0;
         ack_r <= 1'b0;
         addr_r <= rte_pkg::ADDR_RST;
         sda_oe_n_r <= 1'b1;
         wcnt_r <= 24'h000000;
         busy_r <= 1'b0;
      end else if (st_r == rte_pkg::S_BUSY) begin
         sda_oe_n_r <= 1'b1;
         wcnt_r <= wcnt_r + 24'h000001;
         if (wr_done) begin
            st_r <= rte_pkg::S_IDLE;
            busy_r <= 1'b0;
         end
      end else if (start) begin
         st_r <= rte_pkg::S_RX;
         bit_r <= 4'h0;
         idx_r <= rte_pkg::IDX_SLAVE;
         wrote_r <= 1'b0;
         sda_oe_n_r <= 1'b1;
      end else if (stop) begin
         // Write cycle if a data byte came in, else standby until the next start; the address already stands loaded
         sda_oe_n_r <= 1'b1;
         wcnt_r <= 24'h000000;
         wrote_r <= 1'b0;
         st_r <= go_busy ? rte_pkg::S_BUSY : rte_pkg::S_IDLE;
         busy_r <= go_busy;
      end else begin
         case (st_r)
            rte_pkg::S_RX: begin
               if (scl_rise) begin
                  sh_r <= {sh_r[6:0], sda_in};
                  bit_r <= bit_r + 4'h1;
               end else if (byte_end) begin
                  bit_r <= 4'h0;
                  if (idx_r == rte_pkg::IDX_SLAVE && !addr_hit) begin
                     st_r <= rte_pkg::S_IDLE;
                  end else begin
                     st_r <= rte_pkg::S_ACK;
                     sda_oe_n_r <= 1'b0;
                     if (idx_r != rte_pkg::IDX_DATA) begin
                        idx_r <= idx_r + 2'h1;
                     end
                     case (idx_r)
                        rte_pkg::IDX_SLAVE: begin
                           rd_r <= sh_r[0];
                           ctl_r <= ctl_hit;
                        end
                        rte_pkg::IDX_HI: hi_r <= sh_r;
                        rte_pkg::IDX_LO: addr_r <= {hi_r, sh_r};
                        default: begin
                           wrote_r <= 1'b1;
                           addr_r <= next_addr(addr_r, wr_mask, 1'b1);
                        end
                     endcase
                  end
               end
            end
            rte_pkg::S_ACK: begin
               if (load_tx) begin
                  sh_r <= rd_byte;
                  sda_oe_n_r <= rd_byte[7];
                  bit_r <= 4'h1;
                  st_r <= rte_pkg::S_TX;
               end else if (scl_fall) begin
                  sda_oe_n_r <= 1'b1;
                  st_r <= rte_pkg::S_RX;
               end
            end
            rte_pkg::S_TX: begin
               if (scl_fall) begin
                  if (bit_r == rte_pkg::BITS) begin
                     sda_oe_n_r <= 1'b1;
                     st_r <= rte_pkg::S_MACK;
                     addr_r <= next_addr(addr_r, rd_mask, 1'b0);
                  end else begin
                     sda_oe_n_r <= sh_r[6];
                     sh_r <= {sh_r[6:0], 1'b0};
                     bit_r <= bit_r + 4'h1;
                  end
               end
            end
            rte_pkg::S_MACK: begin
               if (scl_rise) begin
                  ack_r <= ~sda_in;
               end else if (load_tx) begin
                  sh_r <= rd_byte;
                  sda_oe_n_r <= rd_byte[7];
                  bit_r <= 4'h1;
                  st_r <= rte_pkg::S_TX;
               end else if (scl_fall) begin
                  st_r <= rte_pkg::S_IDLE;
               end
            end
            default: begin
               sda_oe_n_r <= 1'b1;
            end
         endcase
      end
   end

   // Byte store into the selected space
   always_ff @(posedge clock) begin
      if (wr_en && !ctl_r) begin
         arr_mem[arr_a] <= sh_r;
      end
      if (wr_en && ctl_r) begin
         ctl_mem[ctl_a] <= sh_r;
      end
   end

   // Trim settings mirrored from control-register writes
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         cap_r <= rte_pkg::LOAD_CAP_RST;
         ftrim_r <= rte_pkg::FREQ_TRIM_RST;
      end else if (wr_en && ctl_r) begin
         if (ctl_a == rte_pkg::OFS_LOAD_CAP) begin
            cap_r <= sh_r[5:0];
         end
         if (ctl_a == rte_pkg::OFS_FREQ_TRIM) begin
            ftrim_r <= sh_r[2:0];
         end
      end
   end

   // Digital trim: bit 2 selects skip, bits 1:0 pulses per period
   wire per_end = osc_pulse && (acnt_r == 24'(ADJ_PERIOD - 1));
   wire owing = owe_r != 2'h0;
   wire skip_now = osc_pulse && owing && ftrim_r[2];
   wire add_now = !osc_pulse && owing && !ftrim_r[2];
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         acnt_r <= 24'h000000;
         owe_r <= 2'h0;
         adj_r <= 1'b0;
      end else begin
         if (osc_pulse) begin
            acnt_r <= per_end ? 24'h000000 : acnt_r + 24'h000001;
         end
         if (per_end) begin
            owe_r <= ftrim_r[1:0];
         end else if (skip_now || add_now) begin
            owe_r <= owe_r - 2'h1;
         end
         adj_r <= (osc_pulse && !skip_now) || add_now;
      end
   end

   assign bus.d_sda_o = 1'b0;
   assign bus.d_sda_oe_n = sda_oe_n_r;
   assign busy = busy_r;
   assign load_cap_trim = cap_r;
   assign freq_trim = ftrim_r;
   assign osc_pulse_adj = adj_r;
endmodule : rte_dev

// [include/rte_pkg.sv]
// Purpose: Shared constants and types for the RTC EEPROM two-wire link.
// Assumes: 200 MHz system clock on both ends.
// Notes: Long counts are derived here and overridable at the top modules.
package rte_pkg;
   // Clock and link timing
   localparam int CLK_PERIOD_NS = 5;
   localparam int CLK_MHZ = 1000 / CLK_PERIOD_NS;
   localparam int WR_TIME_MS = 12;
   localparam int WR_CYCLES = WR_TIME_MS * 1000 * 1000 * CLK_MHZ / 1000;
   localparam int SCL_PERIOD_NS = 2500;
   localparam int SCL_QTR = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
   // Slave address patterns, upper seven bits
   localparam logic [6:0] ARR_ID = 7'h57;
   localparam logic [6:0] CTL_ID = 7'h6F;
   // Address spaces
   localparam int ARR_BYTES = 512;
   localparam int ARR_AW = 9;
   localparam int CTL_BYTES = 64;
   localparam int CTL_AW = 6;
   localparam logic [15:0] ADDR_RST = 16'h0000;
   localparam logic [15:0] ARR_MASK = 16'h01FF;
   localparam logic [15:0] CTL_MASK = 16'h003F;
   localparam logic [15:0] ARR_PAGE_MASK = 16'h000F;
   localparam logic [15:0] CTL_PAGE_MASK = 16'h0007;
   // Byte framing
   localparam logic [3:0] BITS = 4'h8;
   localparam logic [1:0] IDX_SLAVE = 2'h0;
   localparam logic [1:0] IDX_HI = 2'h1;
   localparam logic [1:0] IDX_LO = 2'h2;
   localparam logic [1:0] IDX_DATA = 2'h3;
   // Trim settings in the control-register space
   localparam logic [5:0] OFS_LOAD_CAP = 6'h10;
   localparam logic [5:0] OFS_FREQ_TRIM = 6'h11;
   localparam logic [5:0] LOAD_CAP_RST = 6'h20;
   localparam logic [2:0] FREQ_TRIM_RST = 3'h0;
   localparam int PPM_STEP = 10;
   localparam int ADJ_PERIOD = 1000000 / PPM_STEP;
   typedef enum logic [5:0] {
      S_IDLE = 6'h01,
      S_RX = 6'h02,
      S_ACK = 6'h04,
      S_TX = 6'h08,
      S_MACK = 6'h10,
      S_BUSY = 6'h20
   } rte_dst_t;
   typedef enum logic [3:0] {
      M_IDLE = 4'h1,
      M_START = 4'h2,
      M_BIT = 4'h4,
      M_STOP = 4'h8
   } rte_mst_t;
   typedef enum logic [1:0] {
      OP_START = 2'h0,
      OP_WR = 2'h1,
      OP_RD = 2'h2,
      OP_STOP = 2'h3
   } rte_op_t;
endpackage : rte_pkg

// [include/rte_if.sv]
// Purpose: Two-wire link between the bus master and the RTC EEPROM end.
// Assumes: Open-drain wires; an enable low pulls the wire low.
// Notes: Wire levels are resolved here from the drivers' enables.
`timescale 1ns/100ps
interface rte_if;
   logic m_scl_o;
   logic m_scl_oe_n;
   logic m_sda_o;
   logic m_sda_oe_n;
   logic d_sda_o;
   logic d_sda_oe_n;
   logic scl;
   logic sda;
   assign scl = m_scl_oe_n | m_scl_o;
   assign sda = (m_sda_oe_n | m_sda_o) & (d_sda_oe_n | d_sda_o);
   modport dev (input scl, input sda, output d_sda_o, output d_sda_oe_n);
   modport host (input sda, output m_scl_o, output m_scl_oe_n, output m_sda_o,
      output m_sda_oe_n);
endinterface : rte_if

// [rtl/rte_host.sv]
// Purpose: Two-wire bus master issuing start, byte, and stop operations.
// Assumes: SCL made here by a divider; SDA sampled through two flip-flops.
// Notes: The user sequences operations; one operation at a time.
`timescale 1ns/100ps
module rte_host #(
   parameter int SCL_QTR = rte_pkg::SCL_QTR
) (
   input wire logic clock, // System clock
   input wire logic resetn, // Async reset, active low
   rte_if.host bus, // Two-wire link
   input wire logic op_valid, // Operation request
   input wire logic [1:0] op_code, // Start, write, read, stop
   input wire logic [7:0] op_wdata, // Byte to send
   input wire logic op_ack, // Acknowledge a read byte
   output logic op_ready, // Ready for an operation
   output logic done, // Operation finished, one cycle
   output logic [7:0] rdata, // Byte read
   output logic ack_seen // Slave acknowledged the written byte
);
   if (SCL_QTR < 4 || SCL_QTR >= 2 ** 16) begin : g_chk_qtr
      $error("SCL_QTR out of range");
   end

   logic [1:0] sda_s;
   rte_pkg::rte_mst_t st_r;
   logic [15:0] div_r;
   logic [1:0] q_r;
   logic [3:0] bit_r;
   logic [8:0] tx_r;
   logic [8:0] rx_r;
   logic scl_oe_n_r;
   logic sda_oe_n_r;
   logic ready_r;
   logic done_r;
   logic [7:0] rdata_r;
   logic ack_r;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         sda_s <= 2'h3;
      end else begin
         sda_s <= {sda_s[0], bus.sda};
      end
   end

   wire tick = div_r == 16'(SCL_QTR - 1);
   wire last_q = tick && (q_r == 2'h3);
   wire bit_last = bit_r == rte_pkg::BITS;
   wire finish = last_q && ((st_r != rte_pkg::M_BIT) || bit_last);
   wire take = ready_r && op_valid;
   // Ninth bit: released after a write, ack or nack after a read
   wire [8:0] tx_load = (op_code == rte_pkg::OP_WR) ? {op_wdata, 1'b1} : {8'hFF, ~op_ack};

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         st_r <= rte_pkg::M_IDLE;
         div_r <= 16'h0000;
         q_r <= 2'h0;
         bit_r <= 4'h0;
         tx_r <= 9'h1FF;
         rx_r <= 9'h000;
         scl_oe_n_r <= 1'b1;
         sda_oe_n_r <= 1'b1;
         ready_r <= 1'b1;
         done_r <= 1'b0;
         rdata_r <= 8'h00;
         ack_r <= 1'b0;
      end else begin
         done_r <= 1'b0;
         div_r <= (tick || st_r == rte_pkg::M_IDLE) ? 16'h0000 : div_r + 16'h0001;
         if (tick) begin
            q_r <= q_r + 2'h1;
         end
         if (take) begin
            ready_r <= 1'b0;
            q_r <= 2'h0;
            bit_r <= 4'h0;
            tx_r <= tx_load;
            case (op_code)
               rte_pkg::OP_START: st_r <= rte_pkg::M_START;
               rte_pkg::OP_STOP: st_r <= rte_pkg::M_STOP;
               default: st_r <= rte_pkg::M_BIT;
            endcase
         end else if (tick) begin
            case (st_r)
               rte_pkg::M_START: begin
                  case (q_r)
                     2'h0: sda_oe_n_r <= 1'b1;
                     2'h1: scl_oe_n_r <= 1'b1;
                     2'h2: sda_oe_n_r <= 1'b0;
                     default: scl_oe_n_r <= 1'b0;
                  endcase
               end
               rte_pkg::M_BIT: begin
                  case (q_r)
                     2'h0: sda_oe_n_r <= tx_r[8];
                     2'h1: scl_oe_n_r <= 1'b1;
                     2'h2: rx_r <= {rx_r[7:0], sda_s[1]};
                     default: begin
                        scl_oe_n_r <= 1'b0;
                        tx_r <= {tx_r[7:0], 1'b1};
                        bit_r <= bit_r + 4'h1;
                     end
                  endcase
               end
               rte_pkg::M_STOP: begin
                  case (q_r)
                     2'h0: sda_oe_n_r <= 1'b0;
                     2'h1: scl_oe_n_r <= 1'b1;
                     2'h2: sda_oe_n_r <= 1'b1;
                     default: sda_oe_n_r <= 1'b1;
                  endcase
               end
               default: begin
                  scl_oe_n_r <= scl_oe_n_r;
               end
            endcase
         end
         if (finish) begin
            st_r <= rte_pkg::M_IDLE;
            ready_r <= 1'b1;
            done_r <= 1'b1;
            if (st_r == rte_pkg::M_BIT) begin
               rdata_r <= rx_r[8:1];
               ack_r <= ~rx_r[0];
            end
         end
      end
   end

   assign bus.m_scl_o = 1'b0;
   assign bus.m_sda_o = 1'b0;
   assign bus.m_scl_oe_n = scl_oe_n_r;
   assign bus.m_sda_oe_n = sda_oe_n_r;
   assign op_ready = ready_r;
   assign done = done_r;
   assign rdata = rdata_r;
   assign ack_seen = ack_r;
endmodule : rte_host

// [dv/rte_props.sv]
// Purpose: Concurrent checks on the two-wire link between both ends.
// Assumes: One clock domain; link wires sampled on the system clock.
// Notes: Write-cycle length is counted in helper logic.
`timescale 1ns/100ps
module rte_props #(
   parameter int WR_CYCLES = 2000
) (
   input wire logic clock, // System clock
   input wire logic resetn, // Async reset, active low
   input wire logic m_scl_o, // Master SCL level when pulling
   input wire logic m_scl_oe_n, // Master pulls SCL when low
   input wire logic m_sda_o, // Master SDA level when pulling
   input wire logic m_sda_oe_n, // Master pulls SDA when low
   input wire logic d_sda_o, // Device SDA level when pulling
   input wire logic d_sda_oe_n, // Device pulls SDA when low
   input wire logic scl, // Resolved clock wire
   input wire logic sda, // Resolved data wire
   input wire logic busy // Device write cycle running
);
   localparam int W_LO = WR_CYCLES - 3;
   localparam int W_HI = WR_CYCLES + 3;
   logic [15:0] busy_cnt_r;
   logic [15:0] busy_cnt_nxt;
   default clocking cb @(posedge clock);
   endclocking
   assign busy_cnt_nxt = busy ? busy_cnt_r + 16'h0001 : 16'h0000;
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         busy_cnt_r <= 16'h0000;
      end else begin
         busy_cnt_r <= busy_cnt_nxt;
      end
   end
   sequence s_dev_pull;
      $fell(d_sda_oe_n);
   endsequence
   sequence s_dev_hold;
      !d_sda_oe_n [*8];
   endsequence
   a_ties_low: assert property (disable iff (!resetn)
      !m_scl_o && !m_sda_o && !d_sda_o) else $error("open-drain level not low");
   a_reset_release: assert property (
      !resetn |-> m_scl_oe_n && m_sda_oe_n && d_sda_oe_n) else $error("wire held in reset");
   a_start_idle: assert property (disable iff (!resetn)
      $rose(resetn) |-> !busy) else $error("busy after reset");
   a_busy_silent: assert property (disable iff (!resetn)
      busy |-> d_sda_oe_n) else $error("device drives SDA while busy");
   a_busy_span: assert property (disable iff (!resetn)
      $fell(busy) |-> busy_cnt_r >= W_LO && busy_cnt_r <= W_HI) else $error("busy length");
   a_busy_after_stop: assert property (disable iff (!resetn)
      $rose(busy) |-> scl && sda) else $error("busy without stop");
   a_dev_scl_low: assert property (disable iff (!resetn)
      $changed(d_sda_oe_n) |-> !scl) else $error("device SDA moved with SCL high");
   a_ack_hold: assert property (disable iff (!resetn)
      s_dev_pull |-> s_dev_hold) else $error("device pull too short");
endmodule : rte_props

// [dv/rtc_eeprom_i2c_read_poll_bench.sv]
// Purpose: Bench joining the bus master end to the RTC EEPROM end.
// Assumes: Short write cycle and trim period set by parameters.
// Notes: Rows cover address decode; reads, polling, trims follow.
`timescale 1ns/100ps
module rtc_eeprom_i2c_read_poll_bench;
   localparam int WRC = 2000;
   logic clock = 1'b0;
   // Starts high so the time-zero reset is a real falling edge
   logic resetn = 1'b1;
   logic op_valid = 1'b0;
   logic [1:0] op_code = 2'h0;
   logic [7:0] op_wdata = 8'h00;
   logic op_ack = 1'b0;
   logic osc_pulse = 1'b0;
   logic op_ready, done, ack_seen, busy, osc_pulse_adj;
   logic [7:0] rdata;
   logic [5:0] load_cap_trim;
   logic [2:0] freq_trim;
   int error_cnt = 0;
   int check_count = 0;
   // Rows: expected ack, then slave address byte
   logic [8:0] rows [8] = '{9'h1AE, 9'h1AF, 9'h1DE, 9'h1DF, 9'h0A0, 9'h0AC, 9'h0EE, 9'h05E};
   rte_if bus_if ();
   rte_host #(.SCL_QTR(10)) u_rte_host (.clock(clock), .resetn(resetn), .bus(bus_if),
      .op_valid(op_valid), .op_code(op_code), .op_wdata(op_wdata), .op_ack(op_ack),
      .op_ready(op_ready), .done(done), .rdata(rdata), .ack_seen(ack_seen));
   rte_dev #(.WR_CYCLES(WRC), .ADJ_PERIOD(16)) u_rte_dev (.clock(clock), .resetn(resetn),
      .bus(bus_if), .busy(busy), .load_cap_trim(load_cap_trim), .freq_trim(freq_trim),
      .osc_pulse(osc_pulse), .osc_pulse_adj(osc_pulse_adj));
   rte_props #(.WR_CYCLES(WRC)) u_rte_props (.clock(clock), .resetn(resetn),
      .m_scl_o(bus_if.m_scl_o), .m_scl_oe_n(bus_if.m_scl_oe_n), .m_sda_o(bus_if.m_sda_o),
      .m_sda_oe_n(bus_if.m_sda_oe_n), .d_sda_o(bus_if.d_sda_o),
      .d_sda_oe_n(bus_if.d_sda_oe_n), .scl(bus_if.scl), .sda(bus_if.sda), .busy(busy));
   initial begin
      forever #2.5 clock = ~clock;
   end
   task automatic end_sim();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : end_sim
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : chk
   // One host operation, offered for a single clock, then bounded wait for done
   task automatic op(input logic [1:0] c, input logic [7:0] d, input logic a);
      int n;
      @(posedge clock);
      op_valid <= 1'b1;
      op_code <= c;
      op_wdata <= d;
      op_ack <= a;
      @(posedge clock);
      op_valid <= 1'b0;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (done !== 1'b1 && n < 1000);
      chk({n < 1000, op_ready}, 2'h3);
   endtask : op
   task automatic rd(input logic a, input logic [7:0] exp);
      op(2'h2, 8'h00, a);
      chk(rdata, exp);
   endtask : rd
   task automatic xfer(input logic [7:0] sa, input logic [15:0] wa);
      op(2'h0, 8'h00, 1'b0);
      op(2'h1, sa, 1'b0);
      chk(ack_seen, 1'b1);
      op(2'h1, wa[15:8], 1'b0);
      chk(ack_seen, 1'b1);
      op(2'h1, wa[7:0], 1'b0);
      chk(ack_seen, 1'b1);
   endtask : xfer
   task automatic rd_open();
      op(2'h0, 8'h00, 1'b0);
      op(2'h1, 8'hAF, 1'b0);
      chk(ack_seen, 1'b1);
   endtask : rd_open
   task automatic wr(input logic [7:0] sa, input logic [15:0] wa, input logic [7:0] d);
      int n;
      logic k;
      xfer(sa, wa);
      op(2'h1, d, 1'b0);
      chk(ack_seen, 1'b1);
      op(2'h3, 8'h00, 1'b0);
      chk(busy, 1'b1);
      n = 0;
      k = 1'b0;
      while (k !== 1'b1 && n < 30) begin
         op(2'h0, 8'h00, 1'b0);
         op(2'h1, 8'hAE, 1'b0);
         k = ack_seen;
         op(2'h3, 8'h00, 1'b0);
         if (n == 0) chk(k, 1'b0);
         n++;
      end
      chk(k, 1'b1);
      chk(busy, 1'b0);
   endtask : wr
   // Counts trimmed pulses over 256 source pulses, four cycles apart
   task automatic osc(output int c);
      c = 0;
      repeat (256) begin
         @(posedge clock);
         osc_pulse <= 1'b1;
         if (osc_pulse_adj === 1'b1) c++;
         repeat (3) begin
            @(posedge clock);
            osc_pulse <= 1'b0;
            if (osc_pulse_adj === 1'b1) c++;
         end
      end
   endtask : osc
   task automatic do_reset();
      resetn <= 1'b0;
      repeat (2) @(posedge clock);
      resetn <= 1'b1;
      repeat (4) @(posedge clock);
   endtask : do_reset
   initial begin
      // Roughly twice the expected run length
      #400000;
      error_cnt++;
      end_sim();
   end
   initial begin
      int c;
      do_reset();
      chk(load_cap_trim, 6'h20);
      chk(freq_trim, 3'h0);
      osc(c);
      chk(c, 256);
      foreach (rows[i]) begin
         op(2'h0, 8'h00, 1'b0);
         op(2'h1, rows[i][7:0], 1'b0);
         chk(ack_seen, rows[i][8]);
         if (rows[i][8] && rows[i][0]) op(2'h2, 8'h00, 1'b0);
         op(2'h3, 8'h00, 1'b0);
      end
      wr(8'hAE, 16'h01FE, 8'hAA);
      wr(8'hAE, 16'h01FF, 8'hBB);
      wr(8'hAE, 16'h0000, 8'hCC);
      wr(8'hAE, 16'h0001, 8'hDD);
      // Second reset: counter back to zero
      do_reset();
      rd_open();
      rd(1'b1, 8'hCC);
      rd(1'b0, 8'hDD);
      op(2'h3, 8'h00, 1'b0);
      xfer(8'hAE, 16'h01FF);
      op(2'h3, 8'h00, 1'b0);
      rd_open();
      rd(1'b1, 8'hBB);
      rd(1'b0, 8'hCC);
      op(2'h3, 8'h00, 1'b0);
      rd_open();
      rd(1'b0, 8'hDD);
      op(2'h3, 8'h00, 1'b0);
      xfer(8'hAE, 16'h01FE);
      rd_open();
      rd(1'b1, 8'hAA);
      rd(1'b1, 8'hBB);
      rd(1'b0, 8'hCC);
      op(2'h3, 8'h00, 1'b0);
      wr(8'hDE, 16'h0010, 8'h2A);
      chk(load_cap_trim, 6'h2A);
      wr(8'hDE, 16'h0011, 8'h03);
      chk(freq_trim, 3'h3);
      osc(c);
      chk(c >= 301 && c <= 307, 1'b1);
      wr(8'hDE, 16'h0011, 8'h05);
      osc(c);
      chk(c >= 237 && c <= 243, 1'b1);
      end_sim();
   end
endmodule : rtc_eeprom_i2c_read_poll_bench
